// >>> hdl/tccc_top.sv
// APB register file, channel compare/capture control and interrupt logic of the timer.
// Assumes capture pins are asynchronous to pclk and port direction/data come from pclk logic.
//
// Functional notes
// [RULE1] Compare hit drives pin: none, toggle, low, high.
// [RULE2] Nonzero action pair makes pin compare-driven output.
// [RULE3] Action pairs: ch7-4 high register, ch3-0 low.
// [RULE4] Edge pair: off, rising, falling, or both.
// [RULE5] Per-channel enables gate flags onto interrupt.
// [RULE6] Prescale codes select divide by 1 to 32.
// [RULE7] New prescale loads when prescaler stages are zero; the code loads it on the count tick, with the stages at their top count.
// [RULE8] Flags readable; writing one clears, zero keeps.
// [RULE9] Fast clear: channel access clears channel flag; code clears it only on a capture-channel read or compare-channel write.
// [RULE10] Software avoids stray accesses under fast clear.
// [RULE11] Reserved register reads zero.
// [RULE12] Counter wrap from maximum sets overflow flag.
// [RULE13] Overflow enable gates overflow flag onto interrupt.
// [RULE14] Counter reset enable: channel 7 compare zeroes counter.
`timescale 1ns/1ps
module tccc_top
	import tccc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NUM_CH-1:0] capture_in,
	input wire logic [NUM_CH-1:0] port_direction_bit,
	input wire logic [NUM_CH-1:0] port_data,
	output logic [NUM_CH-1:0] compare_output_line,
	output logic [NUM_CH-1:0] compare_output_line_oe_n,
	output logic irq
);
	logic [NUM_CH-1:0] io_sel_q;
	logic fast_clr_q;
	logic [2*NUM_CH-1:0] act_q;
	logic [2*NUM_CH-1:0] edge_q;
	logic [NUM_CH-1:0] channel_irq_enable;
	logic overflow_irq_enable;
	logic counter_reset_on_ch7;
	logic [PR_W-1:0] prescale_sel_q;
	logic [NUM_CH-1:0] channel_event_flag;
	logic counter_overflow_flag;
	logic [CNT_W-1:0] ch_val_q [NUM_CH];
	logic [NUM_CH-1:0] pin_q;
	logic [NUM_CH-1:0] sync1_q, sync2_q, sync3_q, level_q;
	logic [NUM_CH-1:0] cmp_hit, cap_hit, fast_hit, flag_clr;
	logic [31:0] prdata_q;
	logic pslverr_q;
	logic count_tick, overflow_pulse;
	logic [CNT_W-1:0] count_q;
	logic [IDX_W-1:0] idx;
	logic setup, access, wr_en;
	logic [31:0] rd_mux;

	function automatic logic is_chan(input logic [IDX_W-1:0] i);
		is_chan = (i >= IDX_CH_FIRST) && (i <= IDX_CH_LAST) && !i[0];
	endfunction

	function automatic logic is_mapped(input logic [IDX_W-1:0] i);
		is_mapped = is_chan(i) || (i == IDX_IO_SELECT) || (i == IDX_COUNTER)
			|| ((i >= IDX_FAST_CLEAR) && (i <= IDX_OVF_FLAG));
	endfunction

	// APB: zero wait states; read data and error are taken at the setup edge.
	assign idx = paddr[ADDR_W-1:2];
	assign setup = psel && !penable;
	assign access = psel && penable;
	assign pready = 1'b1;
	assign wr_en = access && pwrite && !pslverr_q && pstrb[0];
	assign prdata = prdata_q;
	assign pslverr = pslverr_q;

	always_comb begin
		rd_mux = RD_ZERO;
		if (is_chan(idx)) begin
			rd_mux[CNT_W-1:0] = ch_val_q[idx[3:1]];
		end else begin
			unique case (idx)
				IDX_IO_SELECT: rd_mux[7:0] = io_sel_q;
				IDX_COUNTER: rd_mux[CNT_W-1:0] = count_q;
				IDX_FAST_CLEAR: rd_mux[FAST_CLR_BIT] = fast_clr_q;
				IDX_RESERVED: rd_mux = RD_ZERO; // RULE11
				IDX_ACT_HIGH: rd_mux[7:0] = act_q[15:8];
				IDX_ACT_LOW: rd_mux[7:0] = act_q[7:0];
				IDX_EDGE_HIGH: rd_mux[7:0] = edge_q[15:8];
				IDX_EDGE_LOW: rd_mux[7:0] = edge_q[7:0];
				IDX_IRQ_EN: rd_mux[7:0] = channel_irq_enable;
				IDX_OVF_CTRL: rd_mux[7:0] = {overflow_irq_enable, 3'h0, counter_reset_on_ch7,
					prescale_sel_q};
				IDX_FLAGS: rd_mux[7:0] = channel_event_flag; // RULE8
				IDX_OVF_FLAG: rd_mux[OVF_FLAG_BIT] = counter_overflow_flag;
				default: rd_mux = RD_ZERO;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= RD_ZERO;
			pslverr_q <= 1'b0;
		end else if (setup) begin
			prdata_q <= pwrite ? RD_ZERO : rd_mux;
			pslverr_q <= (paddr[1:0] != 2'h0) || !is_mapped(idx);
		end
	end

	// Control registers.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			io_sel_q <= RST_BYTE;
			fast_clr_q <= 1'b0;
			act_q <= {RST_BYTE, RST_BYTE};
			edge_q <= {RST_BYTE, RST_BYTE};
			channel_irq_enable <= RST_BYTE;
			overflow_irq_enable <= 1'b0;
			counter_reset_on_ch7 <= 1'b0;
			prescale_sel_q <= '0;
		end else if (wr_en) begin
			unique case (idx)
				IDX_IO_SELECT: io_sel_q <= pwdata[7:0];
				IDX_FAST_CLEAR: fast_clr_q <= pwdata[FAST_CLR_BIT];
				IDX_ACT_HIGH: act_q[15:8] <= pwdata[7:0]; // RULE3
				IDX_ACT_LOW: act_q[7:0] <= pwdata[7:0]; // RULE3
				IDX_EDGE_HIGH: edge_q[15:8] <= pwdata[7:0];
				IDX_EDGE_LOW: edge_q[7:0] <= pwdata[7:0];
				IDX_IRQ_EN: channel_irq_enable <= pwdata[7:0];
				IDX_OVF_CTRL: begin
					overflow_irq_enable <= pwdata[OVF_TOI_BIT];
					counter_reset_on_ch7 <= pwdata[OVF_COUNTER_RESET_ON_CH7_BIT];
					prescale_sel_q <= pwdata[PR_W-1:0];
				end
				default: ;
			endcase
		end
	end

	// Capture pins pass three flops; a level change counts once the last two agree.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_q <= RST_BYTE;
			sync2_q <= RST_BYTE;
			sync3_q <= RST_BYTE;
		end else begin
			sync1_q <= capture_in;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level_q <= RST_BYTE;
		end else begin
			level_q <= (sync2_q == sync3_q) ? sync3_q : level_q;
		end
	end

	genvar n;
	generate
		for (n = 0; n < NUM_CH; n++) begin : g_ch
			logic rise, fall;
			logic [1:0] act, edg;
			assign act = act_q[2*n+1:2*n];
			assign edg = edge_q[2*n+1:2*n];
			assign rise = (sync2_q[n] == sync3_q[n]) && sync3_q[n] && !level_q[n];
			assign fall = (sync2_q[n] == sync3_q[n]) && !sync3_q[n] && level_q[n];
			assign cmp_hit[n] = count_tick && io_sel_q[n] && (count_q == ch_val_q[n]);
			assign cap_hit[n] = !io_sel_q[n] && ((rise && edg[0]) || (fall && edg[1])); // RULE4
			assign fast_hit[n] = fast_clr_q && access && !pslverr_q && is_chan(idx) // RULE9
				&& (idx[3:1] == n) && (pwrite ? io_sel_q[n] : !io_sel_q[n]);

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					ch_val_q[n] <= RST_WORD;
				end else if (cap_hit[n]) begin
					ch_val_q[n] <= count_q;
				end else if (wr_en && io_sel_q[n] && is_chan(idx) && idx[3:1] == n) begin
					ch_val_q[n] <= pwdata[CNT_W-1:0];
				end
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					pin_q[n] <= 1'b0;
				end else if (cmp_hit[n]) begin
					unique case (act)
						ACT_TOGGLE: pin_q[n] <= !pin_q[n]; // RULE1
						ACT_CLEAR: pin_q[n] <= 1'b0; // RULE1
						ACT_SET: pin_q[n] <= 1'b1; // RULE1
						default: ;
					endcase
				end
			end

			// The compare logic takes the pin whatever the port direction says.
			assign compare_output_line[n] = (|act) ? pin_q[n] : port_data[n]; // RULE2
			assign compare_output_line_oe_n[n] = (|act) ? 1'b0 : !port_direction_bit[n]; // RULE2

			chk_pin_clear: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
				cmp_hit[n] && act == ACT_CLEAR |=> !compare_output_line[n])
				else $error("compare clear did not drive pin low");
			chk_pin_toggle: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
				cmp_hit[n] && act == ACT_TOGGLE |=> pin_q[n] != $past(pin_q[n]))
				else $error("compare toggle did not invert pin");
			chk_pin_owned: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
				(|act) |-> !compare_output_line_oe_n[n] && compare_output_line[n] == pin_q[n])
				else $error("compare action pair did not own pin");
			chk_capture_rise: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
				!io_sel_q[n] && edg == EDGE_RISE && fall |-> !cap_hit[n])
				else $error("rising-only capture fired twice");
			chk_capture_latch: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
				cap_hit[n] |=> channel_event_flag[n] && ch_val_q[n] == $past(count_q))
				else $error("capture did not latch counter and flag");
		end
	endgenerate

	// Set wins over any clear in the same cycle.
	assign flag_clr = ((wr_en && idx == IDX_FLAGS) ? pwdata[7:0] : RST_BYTE) | fast_hit;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			channel_event_flag <= RST_BYTE;
		end else begin
			channel_event_flag <= (channel_event_flag & ~flag_clr) | cmp_hit | cap_hit; // RULE8
		end
	end

	// Under fast clear any counter access also clears the overflow flag.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			counter_overflow_flag <= 1'b0;
		end else if (overflow_pulse) begin
			counter_overflow_flag <= 1'b1; // RULE12
		end else if ((wr_en && idx == IDX_OVF_FLAG && pwdata[OVF_FLAG_BIT])
			|| (fast_clr_q && access && !pslverr_q && idx == IDX_COUNTER)) begin
			counter_overflow_flag <= 1'b0;
		end
	end

	assign irq = (|(channel_event_flag & channel_irq_enable)) // RULE5
		|| (counter_overflow_flag && overflow_irq_enable); // RULE13

	tccc_timebase u_timebase (
		.pclk(pclk),
		.presetn(presetn),
		.prescale_sel(prescale_sel_q),
		.ch7_reset_req(counter_reset_on_ch7 && cmp_hit[NUM_CH-1]), // RULE14
		.count_tick(count_tick),
		.count_q(count_q),
		.overflow_pulse(overflow_pulse)
	);

	chk_act_high_write: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
		wr_en && idx == IDX_ACT_HIGH |=> act_q[15:8] == $past(pwdata[7:0]))
		else $error("high action register not written");
	chk_irq_masked: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
		channel_event_flag != RST_BYTE && channel_irq_enable == RST_BYTE
		&& !overflow_irq_enable |-> !irq)
		else $error("masked flag raised interrupt");
	chk_flag_w1c: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
		wr_en && idx == IDX_FLAGS && fast_hit == RST_BYTE |=>
		channel_event_flag == (($past(channel_event_flag) & ~$past(pwdata[7:0]))
		| $past(cmp_hit) | $past(cap_hit)))
		else $error("flag write-one-to-clear wrong");
	chk_fast_clear: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
		fast_hit != RST_BYTE && (cmp_hit | cap_hit) == RST_BYTE |=>
		(channel_event_flag & $past(fast_hit)) == RST_BYTE)
		else $error("fast clear left flag set");
	chk_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
		setup && !pwrite && paddr == {IDX_RESERVED, 2'h0} |=> prdata == RD_ZERO)
		else $error("reserved register read nonzero");
	chk_ovf_flag_set: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
		overflow_pulse |=> counter_overflow_flag)
		else $error("overflow did not set flag");
	chk_ovf_irq: assert property (@(posedge pclk) disable iff (!presetn) // RULE13
		overflow_pulse && overflow_irq_enable && $stable(overflow_irq_enable) |=> irq)
		else $error("enabled overflow gave no interrupt");

	cov_toggle: cover property (@(posedge pclk) disable iff (!presetn)
		cmp_hit[0] && act_q[1:0] == ACT_TOGGLE);
	cov_capture_any: cover property (@(posedge pclk) disable iff (!presetn)
		cap_hit[1] && edge_q[3:2] == EDGE_ANY);
	cov_fast_clear: cover property (@(posedge pclk) disable iff (!presetn)
		fast_hit != RST_BYTE ##1 irq == 1'b0);
	cov_overflow_irq: cover property (@(posedge pclk) disable iff (!presetn)
		counter_overflow_flag && overflow_irq_enable && irq);
endmodule

// >>> hdl/tccc_pkg.sv
// Shared constants for the timer channel capture/compare control block.
// Assumes a 32-bit APB with word-aligned registers; indices are word numbers.
package tccc_pkg;
	localparam int NUM_CH = 8;
	localparam int CNT_W = 16;
	localparam int ADDR_W = 12;
	localparam int IDX_W = ADDR_W - 2;
	localparam int PR_W = 3;
	localparam int DIV_W = 5;

	// Register word indices; byte address is four times the index.
	localparam logic [IDX_W-1:0] IDX_IO_SELECT = 10'h080;
	localparam logic [IDX_W-1:0] IDX_COUNTER = 10'h084;
	localparam logic [IDX_W-1:0] IDX_FAST_CLEAR = 10'h086;
	localparam logic [IDX_W-1:0] IDX_RESERVED = 10'h087;
	localparam logic [IDX_W-1:0] IDX_ACT_HIGH = 10'h088;
	localparam logic [IDX_W-1:0] IDX_ACT_LOW = 10'h089;
	localparam logic [IDX_W-1:0] IDX_EDGE_HIGH = 10'h08A;
	localparam logic [IDX_W-1:0] IDX_EDGE_LOW = 10'h08B;
	localparam logic [IDX_W-1:0] IDX_IRQ_EN = 10'h08C;
	localparam logic [IDX_W-1:0] IDX_OVF_CTRL = 10'h08D;
	localparam logic [IDX_W-1:0] IDX_FLAGS = 10'h08E;
	localparam logic [IDX_W-1:0] IDX_OVF_FLAG = 10'h08F;
	localparam logic [IDX_W-1:0] IDX_CH_FIRST = 10'h090;
	localparam logic [IDX_W-1:0] IDX_CH_LAST = 10'h09E;

	// Field positions.
	localparam int OVF_TOI_BIT = 7;
	localparam int OVF_COUNTER_RESET_ON_CH7_BIT = 3;
	localparam int FAST_CLR_BIT = 4;
	localparam int OVF_FLAG_BIT = 7;

	// Compare actions and edge configurations, as mode/level and high/low pairs.
	localparam logic [1:0] ACT_TOGGLE = 2'h1;
	localparam logic [1:0] ACT_CLEAR = 2'h2;
	localparam logic [1:0] ACT_SET = 2'h3;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_ANY = 2'h3;

	localparam logic [PR_W-1:0] PR_MAX_CODE = 3'h5;
	localparam logic [PR_W-1:0] PR_DIV8 = 3'h3;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [CNT_W-1:0] RST_WORD = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
	localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
	localparam logic [DIV_W-1:0] DIV_ZERO = 5'h00;
	localparam logic [DIV_W-1:0] DIV_ONE = 5'h01;
	localparam logic [31:0] RD_ZERO = 32'h0000_0000;
endpackage

// >>> hdl/tccc_timebase.sv
// Prescaler and 16-bit free-running counter of the timer.
// Assumes the reset request arrives in the same cycle as the count tick it acts on.
`timescale 1ns/1ps
module tccc_timebase
	import tccc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [PR_W-1:0] prescale_sel,
	input wire logic ch7_reset_req,
	output logic count_tick,
	output logic [CNT_W-1:0] count_q,
	output logic overflow_pulse
);
	logic [DIV_W-1:0] div_q;
	logic [PR_W-1:0] active_sel_q;

	function automatic logic [DIV_W-1:0] div_limit(input logic [PR_W-1:0] sel);
		div_limit = DIV_ZERO;
		for (int i = 0; i < DIV_W; i++) begin
			if (i < int'(sel)) begin
				div_limit[i] = 1'b1;
			end
		end
	endfunction

	assign count_tick = (div_q == div_limit(active_sel_q)); // RULE6
	assign overflow_pulse = count_tick && !ch7_reset_req && (count_q == CNT_MAX); // RULE12

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q <= DIV_ZERO;
		end else if (count_tick) begin
			div_q <= DIV_ZERO;
		end else begin
			div_q <= div_q + DIV_ONE;
		end
	end

	// Loading only on the tick keeps a change of factor from slicing a period short.
	// Reserved codes are never loaded, so the previous factor stays in force.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			active_sel_q <= '0;
		end else if (count_tick && (prescale_sel <= PR_MAX_CODE)) begin
			active_sel_q <= prescale_sel; // RULE7
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_q <= RST_WORD;
		end else if (count_tick) begin
			if (ch7_reset_req) begin
				count_q <= RST_WORD; // RULE14
			end else begin
				count_q <= count_q + CNT_ONE; // RULE12
			end
		end
	end

	chk_presc_load_edge: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
		$changed(active_sel_q) |-> $past(count_tick) && $past(div_q) != DIV_ZERO || $past(active_sel_q) == 3'h0)
		else $error("prescale factor changed away from a tick");
	chk_presc_div8: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
		count_tick && active_sel_q == PR_DIV8 && prescale_sel == PR_DIV8
		|=> !count_tick [*7] ##1 count_tick)
		else $error("divide by eight spacing wrong");
	chk_counter_wrap: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
		overflow_pulse |=> count_q == RST_WORD)
		else $error("counter did not wrap to zero");
	chk_ch7_reset: assert property (@(posedge pclk) disable iff (!presetn) // RULE14
		count_tick && ch7_reset_req |=> count_q == RST_WORD)
		else $error("channel 7 compare did not reset counter");
	chk_count_step: assert property (@(posedge pclk) disable iff (!presetn) // RULE14
		count_tick && !ch7_reset_req |=> count_q == $past(count_q) + CNT_ONE)
		else $error("counter did not advance by one");
endmodule

// >>> testbench/test_timer_channel_capture_compare_ctrl.sv
// Self-checking bench for the timer channel capture/compare control block.
// Assumes the APB slave of tccc_top and a counter that ticks every cycle after reset.
`timescale 1ns/1ps
module test_timer_channel_capture_compare_ctrl;
	import tccc_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err, pin_exp;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, rd, cnt, fl, en, d;
	logic [3:0] pstrb;
	logic [NUM_CH-1:0] capture_in, port_direction_bit, port_data, compare_output_line;
	logic [NUM_CH-1:0] compare_output_line_oe_n;
	logic [1:0] act_seq [5] = '{2'h1, 2'h2, 2'h3, 2'h1, 2'h0};
	logic [IDX_W-1:0] rst_list [6] = '{IDX_ACT_HIGH, IDX_ACT_LOW, IDX_IRQ_EN, IDX_OVF_CTRL,
		IDX_FLAGS, IDX_RESERVED};
	int failures, cmp_count, n, k;

	tccc_top tccc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .capture_in(capture_in),
		.port_direction_bit(port_direction_bit), .port_data(port_data),
		.compare_output_line(compare_output_line),
		.compare_output_line_oe_n(compare_output_line_oe_n), .irq(irq));

	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One APB transfer; read data and error are taken at the edge that sees pready.
	task automatic apb(input logic wr, input logic [IDX_W-1:0] idx, input logic [31:0] wd);
		int t;
		t = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			t++;
		end while (pready !== 1'b1 && t < 20);
		if (t >= 20) begin
			failures++;
			give_verdict();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wait_flag(input int ch);
		int t;
		t = 0;
		do begin
			apb(1'b0, IDX_FLAGS, RD_ZERO);
			t++;
		end while (rd[ch] !== 1'b1 && t < 100);
		if (t >= 100) begin
			failures++;
			give_verdict();
		end
	endtask

	function automatic logic [IDX_W-1:0] pick(input int ch, input logic [IDX_W-1:0] hi);
		return (ch >= 4) ? hi : hi + 10'h001;
	endfunction

	function automatic logic [31:0] pair_at(input int ch, input logic [1:0] p);
		return 32'({6'h00, p} << ((ch % 4) * 2));
	endfunction

	function automatic logic next_pin(input logic [1:0] a, input logic p);
		return (a == ACT_TOGGLE) ? ~p : (a == ACT_CLEAR) ? 1'b0 : (a == ACT_SET) ? 1'b1 : p;
	endfunction

	function automatic logic [7:0] oe_exp(input int ch, input logic [1:0] a);
		logic [7:0] v;
		v = ~port_direction_bit;
		if (a != 2'h0) begin
			v[ch] = 1'b0;
		end
		return v;
	endfunction

	// Counter advance over the 67 cycles between two counter reads, with one tick of slack.
	function automatic logic div_ok(input logic [31:0] delta, input int code);
		int f, p;
		f = (code < 6) ? (1 << code) : 32;
		p = int'(delta[15:0]) * f;
		return (p >= 67 - f) && (p <= 67 + f);
	endfunction

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		pstrb = 4'hF;
		capture_in = '0;
		port_direction_bit = '0;
		port_data = '0;
		failures = 0;
		cmp_count = 0;
		void'($urandom(59));
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		port_data <= 8'($urandom);
		port_direction_bit <= 8'($urandom);
		foreach (rst_list[i]) begin
			apb(1'b0, rst_list[i], RD_ZERO);
			chk(rd, RD_ZERO);
		end
		for (k = 0; k < 3; k++) begin
			d = 32'($urandom_range(255, 0));
			apb(1'b1, rst_list[k], d);
			apb(1'b0, rst_list[k], RD_ZERO);
			chk(rd, d);
			apb(1'b1, rst_list[k], RD_ZERO);
		end
		apb(1'b1, IDX_RESERVED, 32'h0000_00FF);
		apb(1'b0, IDX_RESERVED, RD_ZERO);
		chk(rd, RD_ZERO);
		apb(1'b0, IDX_CH_FIRST + 10'h001, RD_ZERO);
		chk(err, 32'h0000_0001);
		// Every compare action in turn on one channel, tracking the pin from its reset level.
		n = $urandom_range(7, 0);
		en = 32'($urandom_range(255, 0));
		pin_exp = 1'b0;
		apb(1'b1, IDX_IO_SELECT, 32'h0000_00FF);
		apb(1'b1, IDX_IRQ_EN, en);
		foreach (act_seq[i]) begin
			apb(1'b1, pick(n, IDX_ACT_HIGH), pair_at(n, act_seq[i]));
			apb(1'b1, IDX_FLAGS, 32'h0000_00FF);
			apb(1'b0, IDX_COUNTER, RD_ZERO);
			apb(1'b1, IDX_CH_FIRST + 10'(2 * n), rd + 32'h0000_0028);
			wait_flag(n);
			fl = rd;
			pin_exp = next_pin(act_seq[i], pin_exp);
			chk(compare_output_line[n], (act_seq[i] == 2'h0) ? port_data[n] : pin_exp);
			chk(compare_output_line_oe_n, oe_exp(n, act_seq[i]));
			chk(irq, |(fl & en));
		end
		apb(1'b1, IDX_FLAGS, RD_ZERO);
		apb(1'b0, IDX_FLAGS, RD_ZERO);
		chk(rd[n], 1'b1);
		apb(1'b1, IDX_FLAGS, 32'(1) << n);
		apb(1'b0, IDX_FLAGS, RD_ZERO);
		chk(rd[n], 1'b0);
		chk(irq, |(rd & en));
		apb(1'b1, IDX_IRQ_EN, RD_ZERO);
		// Same channel as a capture input, both edges under every edge setting.
		apb(1'b1, IDX_IO_SELECT, 32'(8'hFF ^ (8'h01 << n)));
		for (k = 0; k < 4; k++) begin
			apb(1'b1, pick(n, IDX_EDGE_HIGH), pair_at(n, 2'(k)));
			apb(1'b1, IDX_FLAGS, 32'h0000_00FF);
			capture_in[n] <= 1'b1;
			repeat (8) @(posedge pclk);
			apb(1'b0, IDX_FLAGS, RD_ZERO);
			chk(rd[n], k[0]);
			if (k == 3) begin
				apb(1'b1, IDX_FAST_CLEAR, 32'h0000_0010);
				apb(1'b0, IDX_CH_FIRST + 10'(2 * n), RD_ZERO);
				apb(1'b0, IDX_FLAGS, RD_ZERO);
				chk(rd[n], 1'b0);
				apb(1'b1, IDX_FAST_CLEAR, RD_ZERO);
			end
			apb(1'b1, IDX_FLAGS, 32'h0000_00FF);
			capture_in[n] <= 1'b0;
			repeat (8) @(posedge pclk);
			apb(1'b0, IDX_FLAGS, RD_ZERO);
			chk(rd[n], k[1]);
		end
		// Code 6 is reserved, so the divide by 32 of code 5 must stay in force.
		for (k = 0; k < 7; k++) begin
			apb(1'b1, IDX_OVF_CTRL, 32'(k));
			repeat (70) @(posedge pclk);
			apb(1'b0, IDX_COUNTER, RD_ZERO);
			cnt = rd;
			repeat (64) @(posedge pclk);
			apb(1'b0, IDX_COUNTER, RD_ZERO);
			chk(div_ok(rd - cnt, k), 32'h0000_0001);
		end
		apb(1'b1, IDX_IO_SELECT, 32'h0000_00FF);
		apb(1'b1, IDX_OVF_CTRL, 32'h0000_0008);
		apb(1'b1, IDX_FLAGS, 32'h0000_00FF);
		apb(1'b0, IDX_COUNTER, RD_ZERO);
		apb(1'b1, IDX_CH_LAST, rd + 32'h0000_0028);
		wait_flag(7);
		apb(1'b0, IDX_COUNTER, RD_ZERO);
		chk(rd < 32'h0000_0010, 32'h0000_0001);
		// The wrap takes nearly 65536 ticks at divide by 1, as the counter starts just past zero; this dominates the run time.
		apb(1'b1, IDX_OVF_CTRL, 32'h0000_0080);
		k = 0;
		while (irq !== 1'b1 && k < 70000) begin
			@(posedge pclk);
			k++;
		end
		if (k >= 70000) begin
			failures++;
			give_verdict();
		end
		apb(1'b1, IDX_OVF_CTRL, RD_ZERO);
		apb(1'b0, IDX_OVF_FLAG, RD_ZERO);
		chk(rd, 32'h0000_0080);
		chk(irq, 32'h0000_0000);
		apb(1'b1, IDX_OVF_FLAG, 32'h0000_0080);
		apb(1'b1, IDX_OVF_CTRL, 32'h0000_0080);
		apb(1'b0, IDX_OVF_FLAG, RD_ZERO);
		chk(rd, RD_ZERO);
		chk(irq, 32'h0000_0000);
		give_verdict();
	end
endmodule
